// *** snd_map.svh ***
// Register indices, field positions, reset values, write masks and phase error limits of the detector bank.
// Assumes byte address = 4 * index on a 32-bit APB; included by bare name.
`ifndef SND_MAP_SVH
`define SND_MAP_SVH

// Register indices; the APB byte address is four times the index.
`define SND_IDX_SIGDET_CFG 12'h043
`define SND_IDX_NOISE_THR  12'h044
`define SND_IDX_NOISE_CFG  12'h045
`define SND_IDX_PROP_CFG   12'h046
`define SND_IDX_STATUS     12'h060

// Reset values.
`define SND_RST_SIGDET_CFG 8'h00
`define SND_RST_NOISE_THR  8'h00
`define SND_RST_NOISE_CFG  8'h07
`define SND_RST_PROP_CFG   8'he6

// Writable bit masks; unused bits stay zero.
`define SND_MASK_SIGDET_CFG 8'h07
`define SND_MASK_FULL       8'hff

// Field positions.
`define SND_F_RUN_CNT   0
`define SND_F_WAKE_CNT  1
`define SND_F_READ_SRC  2
`define SND_F_SLEW      1:0
`define SND_F_LEVEL     3:2
`define SND_F_MODE      5:4
`define SND_F_RANGE     7:6
`define SND_F_PROP_SATURATION_SEL      1:0
`define SND_F_PROP_GAIN_SEL      3:2
`define SND_F_INNER     4
`define SND_F_OUTER     5
`define SND_F_RECOVERY_PEAK_SLEW_SEL      7:6

// Phase error thresholds in sixteenths of a bit.
`define SND_OUTER_LIMIT 7
`define SND_INNER_LIMIT 1

`endif

// *** snd_pkg.sv ***
// Types shared by the detector configuration bank.
// Assumes nothing of its surroundings.
package snd_pkg;
  // Detector mode, in field code order.
  typedef enum logic [1:0] {
    SND_MODE_SQUELCH,
    SND_MODE_NOISE,
    SND_MODE_BOTH,
    SND_MODE_BOTH_GATED
  } snd_mode_t;
  typedef logic [7:0] snd_reg_t;
endpackage

// *** snd_noise_decode.sv ***
// Combinational decode of the noise detector configuration byte.
// Assumes its inputs come from registers on the same clock.
`include "snd_map.svh"
module snd_noise_decode (
  // Configuration and detector inputs.
  input  wire logic [7:0] cfg,
  input  wire logic       low_exceeded,
  input  wire logic       noise_raw,
  // Decoded controls.
  output logic [2:0]      range_shift,
  output logic            sig_det_en,
  output logic            noise_det_en,
  output logic            noise_valid,
  output logic [2:0]      level_eighths,
  output logic [3:0]      slew_shift
);
  snd_pkg::snd_mode_t mode;

  // Range 2^7 down to 2^4, level 4/8..1/8, slew 1/256..1/32.
  always_comb begin
    mode         = snd_pkg::snd_mode_t'(cfg[`SND_F_MODE]);
    range_shift  = 3'h7 - {1'b0, cfg[`SND_F_RANGE]};
    slew_shift   = 4'h8 - {2'h0, cfg[`SND_F_SLEW]};
    sig_det_en   = 1'b1;
    noise_det_en = 1'b1;
    noise_valid  = noise_raw;
    case (cfg[`SND_F_LEVEL])
      2'h0:    level_eighths = 3'h4;
      2'h1:    level_eighths = 3'h3;
      2'h2:    level_eighths = 3'h2;
      default: level_eighths = 3'h1;
    endcase
    case (mode)
      snd_pkg::SND_MODE_SQUELCH: begin
        noise_det_en = 1'b0;
        noise_valid  = 1'b0;
      end
      snd_pkg::SND_MODE_NOISE:   sig_det_en = 1'b0;
      snd_pkg::SND_MODE_BOTH:    noise_valid = noise_raw;
      default:                   noise_valid = noise_raw & low_exceeded;
    endcase
  end
endmodule

// *** snd_prop_path.sv ***
// Proportional path of the clock recovery loop filter: tolerance, gain, saturation.
// Assumes phase error arrives in signed sixteenths of a bit on the same clock.
`include "snd_map.svh"
module snd_prop_path #(
  parameter int W = 6
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Error and settings.
  input  wire logic signed [W-1:0] err_in,
  input  wire logic                outer_en,
  input  wire logic                inner_en,
  input  wire logic [1:0]          gain_sel,
  input  wire logic [1:0]          sat_sel,
  // Conditioned proportional term.
  output logic signed [W-1:0]      prop_out
);
  logic signed [W-1:0] next_prop_out;
  logic        [W-1:0] mag;
  logic signed [W-1:0] tol;
  logic signed [W-1:0] scaled;
  logic signed [W-1:0] lim;

  // Tolerance windows zero the error, then shift and clamp it symmetrically.
  always_comb begin
    mag = err_in[W-1] ? W'(-err_in) : W'(err_in);
    tol = err_in;
    if (outer_en && mag > W'(`SND_OUTER_LIMIT)) tol = '0;
    if (inner_en && mag < W'(`SND_INNER_LIMIT)) tol = '0;
    scaled = tol >>> gain_sel;
    lim    = W'(1) <<< sat_sel;
    next_prop_out = scaled;
    if (scaled > lim) next_prop_out = lim;
    else if (scaled < -lim) next_prop_out = -lim;
  end

  // Output register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prop_out <= '0;
    else prop_out <= next_prop_out;
  end

  // The first edge after reset release is skipped so the reset value is not judged.
  a_outer_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (outer_en && (err_in > W'(`SND_OUTER_LIMIT) || err_in < -W'(`SND_OUTER_LIMIT)))
    |=> prop_out == 0) else $error("outer tolerance did not zero the error");
  a_inner_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (inner_en && err_in == 0 && !outer_en) |=> prop_out == 0)
    else $error("inner tolerance did not zero the error");
  a_sat_bound: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> (prop_out <= (W'(1) <<< $past(sat_sel)) &&
               prop_out >= -(W'(1) <<< $past(sat_sel))))
    else $error("proportional term exceeds saturation");
endmodule

// *** snd_config.sv ***
// Signal and noise detector configuration bank with APB slave and readout.
// Assumes APB and detector datapath share SYS_CLK; no wait states are inserted.
//
// Design decision made here: register access over APB.
`include "snd_map.svh"
module snd_config #(
  parameter int PW           = 16,
  parameter int PHASE_W      = 6,
  parameter int BIT_SAMPLES  = 16
) (
  // Clock and reset.
  input  wire logic               SYS_CLK,
  input  wire logic               RESETN,
  // APB slave.
  input  wire logic [13:0]        PADDR,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [31:0]        PWDATA,
  output logic [31:0]             PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  // Detector datapath inputs.
  input  wire logic [PW-1:0]      SIG_POWER,
  input  wire logic [PW-1:0]      SIG_LOW_LEVEL,
  input  wire logic               LOW_THRESH_EXCEEDED,
  input  wire logic               NOISE_DETECT_RAW,
  input  wire logic signed [PHASE_W-1:0] PHASE_ERR_IN,
  // Signal detector controls.
  output logic [PW-1:0]           SIGNAL_POWER_READOUT,
  output logic [7:0]              RUN_THRESH_COUNT,
  output logic [7:0]              WAKE_THRESH_COUNT,
  output logic                    SIGNAL_DET_EN,
  // Noise detector controls.
  output logic [7:0]              NOISE_THRESHOLD,
  output logic [2:0]              NOISE_RANGE_SHIFT,
  output logic                    NOISE_DET_EN,
  output logic                    NOISE_DETECT,
  output logic [2:0]              NOISE_LEVEL_EIGHTHS,
  output logic [3:0]              NOISE_SLEW_SHIFT,
  // Clock recovery proportional path.
  output logic [1:0]              RECOVERY_PEAK_SLEW_SEL,
  output logic signed [PHASE_W-1:0] PROP_ERR_OUT
);
  localparam logic [7:0] HALF_BIT = 8'(BIT_SAMPLES / 2);

  // Register storage.
  logic [7:0] sigdet_cfg;
  logic [7:0] noise_thr;
  logic [7:0] noise_cfg;
  logic [7:0] prop_cfg;
  logic [7:0] next_sigdet_cfg;
  logic [7:0] next_noise_thr;
  logic [7:0] next_noise_cfg;
  logic [7:0] next_prop_cfg;

  // Bus response.
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        setup;
  logic        wr_access;
  logic        known;

  // Registered detector outputs.
  logic [PW-1:0] next_readout;
  logic [7:0]    next_run_count;
  logic [7:0]    next_wake_count;
  logic [2:0]    dec_range;
  logic          dec_sig_en;
  logic          dec_noise_en;
  logic          dec_noise_valid;
  logic [2:0]    dec_level;
  logic [3:0]    dec_slew;

  // Decoded address match, used by both the read and the write paths.
  function automatic logic hit(input logic [13:0] addr, input logic [11:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[13:2] == idx);
  endfunction

  function automatic logic mapped(input logic [13:0] addr);
    mapped = hit(addr, `SND_IDX_SIGDET_CFG) || hit(addr, `SND_IDX_NOISE_THR) ||
             hit(addr, `SND_IDX_NOISE_CFG) || hit(addr, `SND_IDX_PROP_CFG) ||
             hit(addr, `SND_IDX_STATUS);
  endfunction

  // Zero-wait slave: read data and error are prepared in the setup cycle.
  assign PREADY    = 1'b1;
  assign setup     = PSEL && !PENABLE;
  assign known     = mapped(PADDR);
  assign wr_access = PSEL && PENABLE && PWRITE && PREADY && known;

  // Register write path; masks keep unused bits at zero.
  always_comb begin
    next_sigdet_cfg = sigdet_cfg;
    next_noise_thr  = noise_thr;
    next_noise_cfg  = noise_cfg;
    next_prop_cfg   = prop_cfg;
    if (wr_access && hit(PADDR, `SND_IDX_SIGDET_CFG)) begin
      next_sigdet_cfg = PWDATA[7:0] & `SND_MASK_SIGDET_CFG;
    end
    if (wr_access && hit(PADDR, `SND_IDX_NOISE_THR)) begin
      next_noise_thr = PWDATA[7:0];
    end
    if (wr_access && hit(PADDR, `SND_IDX_NOISE_CFG)) begin
      next_noise_cfg = PWDATA[7:0] & `SND_MASK_FULL;
    end
    if (wr_access && hit(PADDR, `SND_IDX_PROP_CFG)) begin
      next_prop_cfg = PWDATA[7:0] & `SND_MASK_FULL;
    end
  end

  // Register storage, reset to documented values.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sigdet_cfg <= `SND_RST_SIGDET_CFG;
      noise_thr  <= `SND_RST_NOISE_THR;
      noise_cfg  <= `SND_RST_NOISE_CFG;
      prop_cfg   <= `SND_RST_PROP_CFG;
    end else begin
      sigdet_cfg <= next_sigdet_cfg;
      noise_thr  <= next_noise_thr;
      noise_cfg  <= next_noise_cfg;
      prop_cfg   <= next_prop_cfg;
    end
  end

  // Read mux and error flag; unmapped addresses read zero with an error.
  always_comb begin
    next_prdata  = PRDATA;
    next_pslverr = PSLVERR;
    if (setup) begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = !known;
      if (!PWRITE) begin
        if (hit(PADDR, `SND_IDX_SIGDET_CFG)) next_prdata = {24'h0, sigdet_cfg};
        if (hit(PADDR, `SND_IDX_NOISE_THR))  next_prdata = {24'h0, noise_thr};
        if (hit(PADDR, `SND_IDX_NOISE_CFG))  next_prdata = {24'h0, noise_cfg};
        if (hit(PADDR, `SND_IDX_PROP_CFG))   next_prdata = {24'h0, prop_cfg};
        if (hit(PADDR, `SND_IDX_STATUS)) begin
          next_prdata = {14'h0, NOISE_DETECT, SIGNAL_DET_EN, PW'(SIGNAL_POWER_READOUT)};
        end
      end
    end
  end

  // Bus response registers.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA  <= next_prdata;
      PSLVERR <= next_pslverr;
    end
  end

  // Decode of the noise detector configuration.
  snd_noise_decode u_noise_decode (
    .cfg           (noise_cfg),
    .low_exceeded  (LOW_THRESH_EXCEEDED),
    .noise_raw     (NOISE_DETECT_RAW),
    .range_shift   (dec_range),
    .sig_det_en    (dec_sig_en),
    .noise_det_en  (dec_noise_en),
    .noise_valid   (dec_noise_valid),
    .level_eighths (dec_level),
    .slew_shift    (dec_slew)
  );

  // Proportional path; the term is registered inside.
  snd_prop_path #(
    .W (PHASE_W)
  ) u_prop_path (
    .clk      (SYS_CLK),
    .rst_n    (RESETN),
    .err_in   (PHASE_ERR_IN),
    .outer_en (prop_cfg[`SND_F_OUTER]),
    .inner_en (prop_cfg[`SND_F_INNER]),
    .gain_sel (prop_cfg[`SND_F_PROP_GAIN_SEL]),
    .sat_sel  (prop_cfg[`SND_F_PROP_SATURATION_SEL]),
    .prop_out (PROP_ERR_OUT)
  );

  // Readout source and half-bit counters.
  always_comb begin
    next_readout    = sigdet_cfg[`SND_F_READ_SRC] ? SIG_LOW_LEVEL : SIG_POWER;
    next_wake_count = sigdet_cfg[`SND_F_WAKE_CNT] ? HALF_BIT : 8'h00;
    next_run_count  = sigdet_cfg[`SND_F_RUN_CNT] ? HALF_BIT : 8'h00;
  end

  // Detector outputs come from flip-flops so the datapath sees glitch-free settings.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SIGNAL_POWER_READOUT   <= '0;
      RUN_THRESH_COUNT       <= 8'h00;
      WAKE_THRESH_COUNT      <= 8'h00;
      SIGNAL_DET_EN          <= 1'b0;
      NOISE_THRESHOLD        <= 8'h00;
      NOISE_RANGE_SHIFT      <= 3'h0;
      NOISE_DET_EN           <= 1'b0;
      NOISE_DETECT           <= 1'b0;
      NOISE_LEVEL_EIGHTHS    <= 3'h0;
      NOISE_SLEW_SHIFT       <= 4'h0;
      RECOVERY_PEAK_SLEW_SEL <= 2'h0;
    end else begin
      SIGNAL_POWER_READOUT   <= next_readout;
      RUN_THRESH_COUNT       <= next_run_count;
      WAKE_THRESH_COUNT      <= next_wake_count;
      SIGNAL_DET_EN          <= dec_sig_en;
      NOISE_THRESHOLD        <= noise_thr;
      NOISE_RANGE_SHIFT      <= dec_range;
      NOISE_DET_EN           <= dec_noise_en;
      NOISE_DETECT           <= dec_noise_valid;
      NOISE_LEVEL_EIGHTHS    <= dec_level;
      NOISE_SLEW_SHIFT       <= dec_slew;
      RECOVERY_PEAK_SLEW_SEL <= prop_cfg[`SND_F_RECOVERY_PEAK_SLEW_SEL];
    end
  end


  // Bus checks: the slave never stalls, refused accesses change nothing.
  a_ready_high: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |->
    PREADY == 1'b1)
    else $error("slave inserted a wait state");
  a_unmapped_err: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (setup && !known) |=>
    (PSLVERR && PRDATA == 32'h0000_0000))
    else $error("unmapped access not refused");
  a_unmapped_write: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (PSEL && PENABLE && PWRITE && !known) |=>
    ($stable(sigdet_cfg) && $stable(noise_thr) && $stable(noise_cfg) && $stable(prop_cfg)))
    else $error("unmapped write changed a register");
  a_sigdet_write: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (wr_access && hit(PADDR, `SND_IDX_SIGDET_CFG)) |=>
    sigdet_cfg == ($past(PWDATA[7:0]) & `SND_MASK_SIGDET_CFG))
    else $error("signal detector write not masked");
  a_noise_cfg_write: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (wr_access && hit(PADDR, `SND_IDX_NOISE_CFG)) |=>
    noise_cfg == $past(PWDATA[7:0]))
    else $error("noise configuration write lost");
  a_prop_cfg_write: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (wr_access && hit(PADDR, `SND_IDX_PROP_CFG)) |=>
    prop_cfg == $past(PWDATA[7:0]))
    else $error("proportional configuration write lost");
  a_read_sigdet: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (setup && !PWRITE && hit(PADDR, `SND_IDX_SIGDET_CFG)) |=>
    PRDATA == {24'h0, $past(sigdet_cfg)})
    else $error("signal detector readback wrong");
  a_read_status: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (setup && !PWRITE && hit(PADDR, `SND_IDX_STATUS)) |=>
    (PRDATA[PW-1:0] == $past(SIGNAL_POWER_READOUT) && PRDATA[PW] == $past(SIGNAL_DET_EN)))
    else $error("status readback wrong");

  // Signal detector settings; the first edge after release is skipped by the RESETN guard.
  a_readout_src: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |=> SIGNAL_POWER_READOUT == ($past(sigdet_cfg[`SND_F_READ_SRC]) ?
                                        $past(SIG_LOW_LEVEL) : $past(SIG_POWER)))
    else $error("power readout source mismatch");
  a_wake_count: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (wr_access && hit(PADDR, `SND_IDX_SIGDET_CFG)) |-> ##2
    WAKE_THRESH_COUNT == ($past(PWDATA[1], 2) ? HALF_BIT : 8'h00))
    else $error("wake counter length wrong");
  a_run_count: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (wr_access && hit(PADDR, `SND_IDX_SIGDET_CFG)) |-> ##2
    RUN_THRESH_COUNT == ($past(PWDATA[0], 2) ? HALF_BIT : 8'h00))
    else $error("run counter length wrong");
  a_wake_value: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |=>
    WAKE_THRESH_COUNT == ($past(sigdet_cfg[`SND_F_WAKE_CNT]) ? HALF_BIT : 8'h00))
    else $error("wake counter does not follow its bit");
  a_run_value: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |=>
    RUN_THRESH_COUNT == ($past(sigdet_cfg[`SND_F_RUN_CNT]) ? HALF_BIT : 8'h00))
    else $error("run counter does not follow its bit");

  // Noise detector settings as seen at the pins.
  a_thresh_write: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (wr_access && hit(PADDR, `SND_IDX_NOISE_THR)) |-> ##2
    NOISE_THRESHOLD == $past(PWDATA[7:0], 2))
    else $error("noise threshold not taken");
  a_thresh_copy: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |=>
    NOISE_THRESHOLD == $past(noise_thr))
    else $error("noise threshold output stale");
  a_range_map: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |=>
    NOISE_RANGE_SHIFT == 3'(7 - $past(noise_cfg[`SND_F_RANGE])))
    else $error("noise range factor wrong");
  a_mode_enables: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (noise_cfg[`SND_F_MODE] == 2'h0) |=>
    (SIGNAL_DET_EN && !NOISE_DET_EN && !NOISE_DETECT))
    else $error("squelch-only mode enables noise");
  a_noise_only: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (noise_cfg[`SND_F_MODE] == 2'h1) |=>
    (!SIGNAL_DET_EN && NOISE_DET_EN && NOISE_DETECT == $past(NOISE_DETECT_RAW)))
    else $error("noise-only mode enables wrong");
  a_both_modes: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (noise_cfg[`SND_F_MODE] == 2'h2) |=>
    (SIGNAL_DET_EN && NOISE_DET_EN && NOISE_DETECT == $past(NOISE_DETECT_RAW)))
    else $error("combined mode enables wrong");
  a_noise_gate: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (noise_cfg[`SND_F_MODE] == 2'h3 && !LOW_THRESH_EXCEEDED) |=>
    !NOISE_DETECT)
    else $error("noise detect valid below low threshold");
  a_gate_pass: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (noise_cfg[`SND_F_MODE] == 2'h3 && LOW_THRESH_EXCEEDED) |=>
    (SIGNAL_DET_EN && NOISE_DET_EN && NOISE_DETECT == $past(NOISE_DETECT_RAW)))
    else $error("gated noise detect lost above low threshold");
  a_level_map: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (noise_cfg[`SND_F_LEVEL] == 2'h1) |=>
    NOISE_LEVEL_EIGHTHS == 3'h3)
    else $error("noise level fraction wrong");
  a_level_codes: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |=>
    NOISE_LEVEL_EIGHTHS == 3'(4 - $past(noise_cfg[`SND_F_LEVEL])))
    else $error("noise level code map wrong");
  a_slew_map: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |=>
    NOISE_SLEW_SHIFT == 4'(8 - $past(noise_cfg[`SND_F_SLEW])))
    else $error("noise slew rate wrong");

  // Recovery settings and reserved bits.
  a_peak_copy: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |=>
    RECOVERY_PEAK_SLEW_SEL == $past(prop_cfg[`SND_F_RECOVERY_PEAK_SLEW_SEL]))
    else $error("recovery peak slew output stale");
  a_unused_zero: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESETN |->
    sigdet_cfg[7:3] == 5'h00)
    else $error("unused configuration bits set");
endmodule

// *** snd_config_test.sv ***
// Self-checking bench for the signal and noise detector configuration bank.
// Assumes snd_map.svh and the design files are compiled before this file.
`include "snd_map.svh"
`define SND_CHK(got, exp, msg) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp); \
  end \
end
module snd_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BS    = 16;
  localparam int LIMIT = 8000;
  typedef struct {bit kind; logic [63:0] v;} snd_note_t;
  // Bench drives and design outputs.
  logic               sys_clk, resetn, psel, penable, pwrite, pready, pslverr, probe_req;
  logic [13:0]        paddr;
  logic [31:0]        pwdata, prdata, wd;
  logic [15:0]        sig_power, sig_low, pwr_out;
  logic               low_exc, raw, sig_en, nd_en, ndet;
  logic signed [5:0]  perr, prop_out;
  logic [7:0]         run_cnt, wake_cnt, thr_out, sd, thr, nd, pc;
  logic [2:0]         rng, lvl;
  logic [3:0]         slew;
  logic [1:0]         peak;
  logic [63:0]        ev;
  logic signed [5:0]  edge_err [6];
  int                 n_errors, samples_checked, cycles, seed;
  snd_note_t          notes [$];
  snd_note_t          cur;
  wire  [63:0]        obs = {3'h0, pwr_out, run_cnt, wake_cnt, sig_en, thr_out, rng, nd_en,
                             ndet, lvl, slew, peak, prop_out};

  snd_config u_snd_config (
    .SYS_CLK(sys_clk), .RESETN(resetn), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SIG_POWER(sig_power), .SIG_LOW_LEVEL(sig_low), .LOW_THRESH_EXCEEDED(low_exc),
    .NOISE_DETECT_RAW(raw), .PHASE_ERR_IN(perr), .SIGNAL_POWER_READOUT(pwr_out),
    .RUN_THRESH_COUNT(run_cnt), .WAKE_THRESH_COUNT(wake_cnt), .SIGNAL_DET_EN(sig_en),
    .NOISE_THRESHOLD(thr_out), .NOISE_RANGE_SHIFT(rng), .NOISE_DET_EN(nd_en),
    .NOISE_DETECT(ndet), .NOISE_LEVEL_EIGHTHS(lvl), .NOISE_SLEW_SHIFT(slew),
    .RECOVERY_PEAK_SLEW_SEL(peak), .PROP_ERR_OUT(prop_out));

  // Free-running 125 MHz clock.
  always #4 sys_clk = ~sys_clk;

  // Proportional term model; int arithmetic keeps the shift rounding toward minus infinity.
  function automatic logic [5:0] prop_exp(input logic signed [5:0] e_in, input logic [7:0] c);
    int e;
    int lim;
    e = e_in;
    lim = 1 << c[1:0];
    if (c[5] && (e > 7 || e < -7)) e = 0;
    if (c[4] && e == 0) e = 0;
    e = e >>> c[3:2];
    if (e > lim) e = lim;
    if (e < -lim) e = -lim;
    return 6'(e);
  endfunction

  // Expected decoded outputs, packed in the same order as obs.
  function automatic logic [63:0] exp_ports();
    logic [1:0] m;
    logic [2:0] lv;
    m = nd[5:4];
    case (nd[3:2])
      2'h0: lv = 3'h4;
      2'h1: lv = 3'h3;
      2'h2: lv = 3'h2;
      default: lv = 3'h1;
    endcase
    return {3'h0, sd[2] ? sig_low : sig_power, sd[0] ? 8'(BS / 2) : 8'h00,
            sd[1] ? 8'(BS / 2) : 8'h00, m != 2'h1, thr, 3'h7 - 3'(nd[7:6]), m != 2'h0,
            (m == 2'h3) ? (raw & low_exc) : ((m != 2'h0) & raw), lv, 4'h8 - 4'(nd[1:0]),
            pc[7:6], prop_exp(perr, pc)};
  endfunction

  function automatic logic [13:0] ba(input logic [11:0] idx);
    return {idx, 2'b00};
  endfunction

  // One APB transfer; an idle edge at the end keeps back-to-back calls from double drives.
  task automatic apb(input logic [13:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Read with the expected {error, data} noted first.
  task automatic rd(input logic [13:0] a, input logic [32:0] e);
    notes.push_back('{1'b0, 64'(e)});
    apb(a, 1'b0, 32'h0);
  endtask

  // Let configuration and datapath settle, then ask the monitor to sample the ports.
  task automatic probe();
    repeat (3) @(posedge sys_clk);
    notes.push_back('{1'b1, exp_ports()});
    probe_req <= 1'b1;
    @(posedge sys_clk);
    probe_req <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask

  task automatic test_done();
    if (notes.size() != 0) n_errors++;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Result watcher: every read completion or port probe consumes the oldest note.
  always @(posedge sys_clk) begin
    if ((psel && penable && pready === 1'b1 && !pwrite) || probe_req) begin
      if (notes.size() == 0) begin
        n_errors++;
        $display("MISMATCH t=%0t result without a note", $time);
      end else begin
        cur = notes.pop_front();
        if (cur.kind) `SND_CHK(obs, cur.v, "ports")
        else `SND_CHK({31'h0, pslverr, prdata}, cur.v, "read")
      end
    end
  end

  // Hang guard: the whole run is a few hundred cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      test_done();
    end
  end

  // Main sequence.
  initial begin
    {sys_clk, resetn, psel, penable, pwrite, probe_req, low_exc, raw} = 8'h00;
    paddr = 14'h0000;
    pwdata = 32'h0;
    sig_power = 16'h0;
    sig_low = 16'h0;
    perr = 6'sh00;
    seed = 26;
    edge_err = '{6'sh07, 6'sh39, 6'sh08, 6'sh38, 6'sh00, 6'sh1f};
    sd = 8'h00;
    thr = 8'h00;
    nd = 8'h07;
    pc = 8'he6;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(ba(`SND_IDX_SIGDET_CFG), 33'h0);
    rd(ba(`SND_IDX_NOISE_THR), 33'h0);
    rd(ba(`SND_IDX_NOISE_CFG), 33'h7);
    rd(ba(`SND_IDX_PROP_CFG), 33'he6);
    probe();
    end_test("reset");
    for (int i = 0; i < 8; i++) begin
      wd = $random(seed);
      wd[2:0] = i[2:0];
      sd = wd[7:0] & `SND_MASK_SIGDET_CFG;
      apb(ba(`SND_IDX_SIGDET_CFG), 1'b1, wd);
      sig_power <= 16'($random(seed));
      sig_low <= 16'($random(seed));
      probe();
      rd(ba(`SND_IDX_SIGDET_CFG), {25'h0, sd});
    end
    end_test("signal detector");
    for (int i = 0; i < 3; i++) begin
      wd = $random(seed);
      thr = wd[7:0];
      apb(ba(`SND_IDX_NOISE_THR), 1'b1, wd);
      rd(ba(`SND_IDX_NOISE_THR), {25'h0, thr});
      probe();
    end
    end_test("noise threshold");
    for (int i = 0; i < 4; i++) begin
      nd = {4{i[1:0]}};
      apb(ba(`SND_IDX_NOISE_CFG), 1'b1, {24'hffffff, nd});
      rd(ba(`SND_IDX_NOISE_CFG), {25'h0, nd});
      for (int j = 0; j < 4; j++) begin
        {raw, low_exc} <= j[1:0];
        probe();
      end
    end
    end_test("noise config");
    for (int k = 0; k < 24; k++) begin
      wd = $random(seed);
      if (k < 12) wd[5] = 1'b1;
      pc = wd[7:0];
      apb(ba(`SND_IDX_PROP_CFG), 1'b1, wd);
      rd(ba(`SND_IDX_PROP_CFG), {25'h0, pc});
      perr <= (k < 6) ? edge_err[k] : 6'($random(seed));
      probe();
    end
    end_test("proportional path");
    rd(14'h0004, 33'h100000000);
    rd({`SND_IDX_NOISE_THR, 2'b01}, 33'h100000000);
    apb(14'h0008, 1'b1, 32'h000000ff);
    rd(ba(`SND_IDX_NOISE_THR), {25'h0, thr});
    {raw, low_exc} <= 2'b11;
    repeat (3) @(posedge sys_clk);
    ev = exp_ports();
    rd(ba(`SND_IDX_STATUS), {1'b0, 14'h0, ev[15], ev[28], ev[60:45]});
    end_test("errors and status");
    test_done();
  end
endmodule
